// ==== common/cpsw_pkg.sv ====
/*
 package of the crosspoint profile switch controller: register offsets,
 field positions, reset values and the packed types shared by the design.
 assumes a 32-bit AHB-Lite register bus and eight ports of three-bit index.
*/
`default_nettype none
package cpsw_pkg;
	localparam int NumPorts = 8;
	localparam int SelW = 3;
	// register byte offsets
	localparam logic [7:0] PrimaryOfs = 8'h00;
	localparam logic [7:0] SecondaryOfs = 8'h04;
	localparam logic [7:0] SwitchCtrlOfs = 8'h08;
	localparam logic [7:0] RouteStatOfs = 8'h0C;
	// switch control field positions
	localparam int RegTrigBit = 0;
	localparam int PinEnBit = 1;
	// status field positions
	localparam int ActiveSecBit = 24;
	localparam int PinLevelBit = 25;
	// reset values
	localparam logic [23:0] IdentityMap = 24'hFA_C688;
	localparam logic [1:0] SwitchCtrlRst = 2'h0;

	typedef logic [SelW-1:0] cpsw_sel_t;

	typedef struct packed {
		logic pinEn;
		logic regTrig;
	} cpsw_ctrl_s;

	typedef struct packed {
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [7:0] haddr;
	} cpsw_addr_s;
endpackage
`default_nettype wire

// ==== logic/cpsw_pin_sync.sv ====
/*
 three-flop synchroniser with agreement filter for the trigger pin.
 assumes the pin is asynchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
module cpsw_pin_sync
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// pin and filtered level
	input wire logic pinAsync,
	output logic pinLevel
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic lvl_q;
	wire agree = (s2_q == s3_q);

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			lvl_q <= 1'b0;
		end
		else
		begin
			s1_q <= pinAsync;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (agree)
				lvl_q <= s3_q;
		end
	end

	assign pinLevel = lvl_q;
endmodule // cpsw_pin_sync
`default_nettype wire

// ==== logic/cpsw_switch_ctrl.sv ====
/*
 crosspoint profile switch controller: AHB-Lite registers, two profiles per
 output, register or pin triggered switch event, routed select outputs.
 assumes one 100 MHz clock, synchronous active-low reset, whole-word access.
*/
`timescale 1ns/100ps
`default_nettype none
module cpsw_switch_ctrl
#(
	parameter int NumPorts = cpsw_pkg::NumPorts
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// register reset pin
	input wire logic config_reset_n,
	// trigger pin
	input wire logic profile_trigger_pin,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// routing
	output logic [NumPorts*cpsw_pkg::SelW-1:0] routeSel,
	output logic useSecondary
);
	localparam int W = NumPorts*cpsw_pkg::SelW;

	//------------------------------------------------------------
	// pin and reset
	//------------------------------------------------------------
	logic pinLevel;
	cpsw_pin_sync uPinSync
	(
		.clk(clk),
		.rst_b(rst_b),
		.pinAsync(profile_trigger_pin),
		.pinLevel(pinLevel)
	);

	logic cr1_q;
	logic cr2_q;
	logic cr3_q;
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			cr1_q <= 1'b1;
			cr2_q <= 1'b1;
			cr3_q <= 1'b1;
		end
		else
		begin
			cr1_q <= config_reset_n;
			cr2_q <= cr1_q;
			cr3_q <= cr2_q;
		end
	end
	wire cfgClear = !rst_b || (!cr2_q && !cr3_q);

	//------------------------------------------------------------
	// bus address phase
	//------------------------------------------------------------
	cpsw_pkg::cpsw_addr_s ap_q;
	logic apValid_q;
	wire take = hsel && hready && htrans[1];
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			ap_q <= '0;
			apValid_q <= 1'b0;
		end
		else if (hready)
		begin
			ap_q <= '{htrans, hwrite, hsize, haddr};
			apValid_q <= take;
		end
	end
	wire wrPhase = apValid_q && ap_q.hwrite;
	wire wrPri = wrPhase && (ap_q.haddr == cpsw_pkg::PrimaryOfs);
	wire wrSec = wrPhase && (ap_q.haddr == cpsw_pkg::SecondaryOfs);
	wire wrCtl = wrPhase && (ap_q.haddr == cpsw_pkg::SwitchCtrlOfs);

	//------------------------------------------------------------
	// profiles and control
	//------------------------------------------------------------
	logic [W-1:0] pri_q;
	logic [W-1:0] sec_q;
	cpsw_pkg::cpsw_ctrl_s ctl_q;
	always_ff @(posedge clk)
	begin
		if (cfgClear)
		begin
			pri_q <= W'(cpsw_pkg::IdentityMap);
			sec_q <= W'(cpsw_pkg::IdentityMap);
			ctl_q <= cpsw_pkg::SwitchCtrlRst;
		end
		else
		begin
			if (wrPri)
				pri_q <= hwdata[W-1:0];
			if (wrSec)
				sec_q <= hwdata[W-1:0];
			if (wrCtl)
			begin
				ctl_q.regTrig <= hwdata[cpsw_pkg::RegTrigBit];
				ctl_q.pinEn <= hwdata[cpsw_pkg::PinEnBit];
			end
		end
	end

	//------------------------------------------------------------
	// profile selection
	//------------------------------------------------------------
	// pin mode follows pin level, register bit ignored
	wire selSecondary = ctl_q.pinEn ? pinLevel : ctl_q.regTrig;
	logic active_q;
	logic [W-1:0] route_q;
	always_ff @(posedge clk)
	begin
		if (cfgClear)
		begin
			active_q <= 1'b0;
			route_q <= W'(cpsw_pkg::IdentityMap);
		end
		else
		begin
			active_q <= selSecondary;
			route_q <= selSecondary ? sec_q : pri_q;
		end
	end
	assign routeSel = route_q;
	assign useSecondary = active_q;

	//------------------------------------------------------------
	// read data
	//------------------------------------------------------------
	// a write still in its data phase is forwarded to a read behind it
	logic [W-1:0] priView;
	logic [W-1:0] secView;
	cpsw_pkg::cpsw_ctrl_s ctlView;
	assign priView = wrPri ? hwdata[W-1:0] : pri_q;
	assign secView = wrSec ? hwdata[W-1:0] : sec_q;
	assign ctlView = wrCtl ? cpsw_pkg::cpsw_ctrl_s'({hwdata[cpsw_pkg::PinEnBit], hwdata[cpsw_pkg::RegTrigBit]})
		: ctl_q;
	logic [31:0] rd_d;
	logic [31:0] rd_q;
	always_comb
	begin
		rd_d = 32'h0000_0000;
		case (haddr)
			cpsw_pkg::PrimaryOfs: rd_d[W-1:0] = priView;
			cpsw_pkg::SecondaryOfs: rd_d[W-1:0] = secView;
			cpsw_pkg::SwitchCtrlOfs:
			begin
				rd_d[cpsw_pkg::RegTrigBit] = ctlView.regTrig;
				rd_d[cpsw_pkg::PinEnBit] = ctlView.pinEn;
			end
			cpsw_pkg::RouteStatOfs:
			begin
				rd_d[W-1:0] = route_q;
				rd_d[cpsw_pkg::ActiveSecBit] = active_q;
				rd_d[cpsw_pkg::PinLevelBit] = pinLevel;
			end
			default: rd_d = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			rd_q <= 32'h0000_0000;
		else if (take && !hwrite)
			rd_q <= rd_d;
	end
	assign hrdata = rd_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	AST_IDENTITY: assert property (@(posedge clk) disable iff (!rst_b)
		(!cr2_q && !cr3_q) |=> (routeSel == W'(cpsw_pkg::IdentityMap) && !useSecondary))
		else $error("reset did not restore identity routing");
	AST_PRIMARY: assert property (@(posedge clk) disable iff (cfgClear)
		!selSecondary |=> (routeSel == $past(pri_q)))
		else $error("primary profile not routed");
	AST_SECONDARY: assert property (@(posedge clk) disable iff (cfgClear)
		selSecondary |=> (routeSel == $past(sec_q)))
		else $error("secondary profile not routed");
	AST_REG_TRIG: assert property (@(posedge clk) disable iff (cfgClear)
		(wrCtl && hwdata[cpsw_pkg::RegTrigBit] && !hwdata[cpsw_pkg::PinEnBit]) |=> ##1 useSecondary)
		else $error("register trigger did not switch");
	AST_PIN_HIGH: assert property (@(posedge clk) disable iff (cfgClear)
		(ctl_q.pinEn && pinLevel) |=> useSecondary)
		else $error("pin high did not switch");
	AST_PIN_FOLLOW: assert property (@(posedge clk) disable iff (cfgClear)
		(ctl_q.pinEn && $changed(pinLevel) && $stable(ctl_q)) |=> (useSecondary == $past(pinLevel)))
		else $error("pin change did not move routing");
	AST_PIN_IGNORE_REG: assert property (@(posedge clk) disable iff (cfgClear)
		(ctl_q.pinEn && !pinLevel && ctl_q.regTrig) |=> !useSecondary)
		else $error("register bit not ignored in pin mode");
	AST_REG_MODE: assert property (@(posedge clk) disable iff (cfgClear)
		(!ctl_q.pinEn) |=> (useSecondary == $past(ctl_q.regTrig)))
		else $error("register mode selection wrong");
	AST_ALL_TOGETHER: assert property (@(posedge clk) disable iff (cfgClear)
		$changed(useSecondary) |-> (routeSel == (useSecondary ? $past(sec_q) : $past(pri_q))))
		else $error("outputs mixed profiles");
	CVR_REG_SWITCH: cover property (@(posedge clk) disable iff (cfgClear)
		!ctl_q.pinEn && $rose(useSecondary));
	CVR_PIN_SWITCH: cover property (@(posedge clk) disable iff (cfgClear)
		ctl_q.pinEn && $rose(useSecondary));
	CVR_PIN_BACK: cover property (@(posedge clk) disable iff (cfgClear)
		ctl_q.pinEn && $fell(useSecondary));
endmodule // cpsw_switch_ctrl
`default_nettype wire

// ==== verification/cpsw_pin_host.sv ====
/*
 far-side model: drives the trigger pin and the register reset pin.
 assumes the bench sets the requested levels just after a rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module cpsw_pin_host
(
	// clock
	input wire logic clk,
	// requests from the bench
	input wire logic trigLvl,
	input wire logic cfgRst,
	// device pins
	output logic profile_trigger_pin,
	output logic config_reset_n
);
	// in pin mode, pin high asks for secondary; each change held two or more clocks moves the set
	always @(posedge clk)
		profile_trigger_pin <= trigLvl;
	// register reset after power-up
	always @(posedge clk)
		config_reset_n <= !cfgRst;
endmodule // cpsw_pin_host
`default_nettype wire

// ==== verification/tb.sv ====
/*
 self-checking bench of the profile switch controller over ahb-lite.
 assumes zero-wait slave and status word {pin, secondary, routing}.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
	logic clk, rst_b, hsel, hwrite, trigLvl, cfgRst, rdTake, hreadyout, hresp, useSecondary;
	logic profile_trigger_pin, config_reset_n;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata;
	logic [23:0] routeSel, pri, sec;
	logic [32:0] expQ[$];
	logic [32:0] e;
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0;
	cpsw_switch_ctrl #(.NumPorts(8)) uut (.clk(clk), .rst_b(rst_b), .config_reset_n(config_reset_n),
		.profile_trigger_pin(profile_trigger_pin), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .routeSel(routeSel), .useSecondary(useSecondary));
	cpsw_pin_host host (.clk(clk), .trigLvl(trigLvl), .cfgRst(cfgRst),
		.profile_trigger_pin(profile_trigger_pin), .config_reset_n(config_reset_n));
	// ----------------------------------------
	// clock, timeout, result watcher
	// ----------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			err_count++;
			conclude();
		end
	end
	always @(posedge clk)
	if (rdTake && hreadyout)
	begin
		e = expQ.pop_front();
		`CHK("hresp", 1'b0, hresp)
		`CHK("hrdata", e[31:0], hrdata)
		if (e[32])
			`CHK("routeSel", e[24:0], {useSecondary, routeSel})
	end
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic busCyc(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		rdTake <= !w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rdTake <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic s);
		expQ.push_back({s, x});
		busCyc(a, 1'b0, 32'h0000_0000);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		busCyc(a, 1'b1, d);
		repeat (2) @(posedge clk);
	endtask
	function automatic logic [31:0] st(input logic s, input logic p, input logic [23:0] r);
		return {6'h00, p, s, r};
	endfunction
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		{hsel, hwrite, trigLvl, cfgRst, rdTake, rst_b} = '0;
		haddr = 8'h00;
		htrans = 2'h0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		void'($urandom(93092));
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd(cpsw_pkg::RouteStatOfs, st(1'b0, 1'b0, cpsw_pkg::IdentityMap), 1'b1);
		rd(cpsw_pkg::SwitchCtrlOfs, 32'h0000_0000, 1'b0);
		$display("reset test done");
		pri = 24'($urandom);
		sec = 24'($urandom);
		wr(cpsw_pkg::PrimaryOfs, {8'h00, pri});
		wr(cpsw_pkg::SecondaryOfs, {8'h00, sec});
		rd(cpsw_pkg::PrimaryOfs, {8'h00, pri}, 1'b0);
		rd(cpsw_pkg::SecondaryOfs, {8'h00, sec}, 1'b0);
		rd(cpsw_pkg::RouteStatOfs, st(1'b0, 1'b0, pri), 1'b1);
		rd(8'h10, 32'h0000_0000, 1'b0);
		wr(cpsw_pkg::SwitchCtrlOfs, 32'h0000_0001);
		rd(cpsw_pkg::RouteStatOfs, st(1'b1, 1'b0, sec), 1'b1);
		wr(cpsw_pkg::SwitchCtrlOfs, 32'h0000_0000);
		rd(cpsw_pkg::RouteStatOfs, st(1'b0, 1'b0, pri), 1'b1);
		$display("register trigger test done");
		wr(cpsw_pkg::SwitchCtrlOfs, 32'h0000_0003);
		for (int i = 0; i < 4; i++)
		begin
			trigLvl <= i[0];
			repeat (8) @(posedge clk);
			rd(cpsw_pkg::RouteStatOfs, st(i[0], i[0], i[0] ? sec : pri), 1'b1);
		end
		$display("pin trigger test done");
		trigLvl <= 1'b0;
		cfgRst <= 1'b1;
		repeat (8) @(posedge clk);
		cfgRst <= 1'b0;
		repeat (8) @(posedge clk);
		rd(cpsw_pkg::PrimaryOfs, {8'h00, cpsw_pkg::IdentityMap}, 1'b0);
		rd(cpsw_pkg::SecondaryOfs, {8'h00, cpsw_pkg::IdentityMap}, 1'b0);
		rd(cpsw_pkg::SwitchCtrlOfs, 32'h0000_0000, 1'b0);
		rd(cpsw_pkg::RouteStatOfs, st(1'b0, 1'b0, cpsw_pkg::IdentityMap), 1'b1);
		$display("pin reset test done");
		wr(cpsw_pkg::PrimaryOfs, {8'h00, sec});
		wr(cpsw_pkg::SwitchCtrlOfs, 32'h0000_0001);
		rst_b <= 1'b0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd(cpsw_pkg::PrimaryOfs, {8'h00, cpsw_pkg::IdentityMap}, 1'b0);
		rd(cpsw_pkg::SwitchCtrlOfs, 32'h0000_0000, 1'b0);
		rd(cpsw_pkg::RouteStatOfs, st(1'b0, 1'b0, cpsw_pkg::IdentityMap), 1'b1);
		$display("mid-run reset test done");
		conclude();
	end
endmodule // tb
`default_nettype wire
